/* File: rcs_pkg.sv */
// Constants for the radio configuration and status register bank
package rcs_pkg;
  // Register addresses
  localparam logic [4:0] ADDR_AW_SETUP    = 5'h03;
  localparam logic [4:0] ADDR_RETR_SETUP  = 5'h04;
  localparam logic [4:0] ADDR_CHANNEL     = 5'h05;
  localparam logic [4:0] ADDR_RADIO_SETUP = 5'h06;
  localparam logic [4:0] ADDR_FLAGS       = 5'h07;
  localparam logic [4:0] ADDR_TX_OBSERVE  = 5'h08;
  localparam logic [4:0] ADDR_POWER_DET   = 5'h09;
  localparam logic [4:0] ADDR_PIPE0       = 5'h0A;
  localparam logic [4:0] ADDR_PIPE1       = 5'h0B;
  localparam logic [4:0] ADDR_PIPE2       = 5'h0C;
  localparam logic [4:0] ADDR_PIPE3       = 5'h0D;
  // Command byte: opcode in bits 7:5, address in bits 4:0
  localparam logic [2:0] CMD_READ         = 3'h0;
  localparam logic [2:0] CMD_WRITE        = 3'h1;
  // Field positions
  localparam int RETRY_DELAY_LSB  = 4;
  localparam int CARRIER_BIT      = 7;
  localparam int LOW_RATE_BIT     = 5;
  localparam int PLL_FORCE_BIT    = 4;
  localparam int HIGH_RATE_BIT    = 3;
  localparam int TX_POWER_LSB     = 1;
  localparam int RX_READY_BIT     = 6;
  localparam int TX_SENT_BIT      = 5;
  localparam int RETRY_LIMIT_BIT  = 4;
  localparam int PIPE_NUM_LSB     = 1;
  localparam int LOST_CNT_LSB     = 4;
  localparam int ADDR_BYTES_MAX   = 5;
  // Reset values
  localparam logic [1:0]  AW_RST          = 2'h3;
  localparam logic [3:0]  RETRY_DELAY_RST = 4'h0;
  localparam logic [3:0]  RETRY_COUNT_RST = 4'h3;
  localparam logic [6:0]  CHANNEL_RST     = 7'h02;
  localparam logic        HIGH_RATE_RST   = 1'b1;
  localparam logic [1:0]  TX_POWER_RST    = 2'h3;
  localparam logic [2:0]  PIPE_NUM_RST    = 3'h7;
  localparam logic [39:0] PIPE0_RST       = 40'hE7E7E7E7E7;
  localparam logic [39:0] PIPE1_RST       = 40'hC2C2C2C2C2;
  localparam logic [7:0]  PIPE2_RST       = 8'hC3;
  localparam logic [7:0]  PIPE3_RST       = 8'hC4;
  // Address width codes
  localparam logic [1:0]  AW_3_BYTES      = 2'h1;
  localparam logic [1:0]  AW_4_BYTES      = 2'h2;
  // Data rate codes on the output
  localparam logic [1:0]  RATE_1M         = 2'h0;
  localparam logic [1:0]  RATE_2M         = 2'h1;
  localparam logic [1:0]  RATE_250K       = 2'h2;
  localparam logic [3:0]  COUNT_MAX       = 4'hF;
  // Retransmit delay step
  localparam int CLK_MHZ                  = 100;
  localparam int RETRY_STEP_US            = 250;
  localparam int RETRY_STEP_CYCLES        = RETRY_STEP_US * CLK_MHZ;
endpackage

/* File: rcs_regs.sv */
// Radio configuration and status register bank behind an internal SPI slave
`timescale 1ns/1ps
module rcs_regs #(
  parameter int RETRY_STEP_CYCLES = rcs_pkg::RETRY_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // Serial port from the controller
  input  wire logic        SCK,
  input  wire logic        CSN_B,
  input  wire logic        MOSI,
  output logic             MISO,
  // Radio events and state
  input  wire logic        RX_READY_PULSE,
  input  wire logic [2:0]  RX_PIPE_NUM,
  input  wire logic        TX_SENT_PULSE,
  input  wire logic        ACK_RECEIVED_PULSE,
  input  wire logic        AUTO_ACK_ON,
  input  wire logic        RETRY_LIMIT_PULSE,
  input  wire logic        TX_FIFO_FULL,
  input  wire logic        LOST_PACKET_PULSE,
  input  wire logic        RETRANSMIT_PULSE,
  input  wire logic        NEW_PACKET_PULSE,
  input  wire logic        TX_END_PULSE,
  input  wire logic        RX_POWER_DETECT,
  // Interrupt masks
  input  wire logic        MASK_RX_READY,
  input  wire logic        MASK_TX_SENT,
  input  wire logic        MASK_RETRY_LIMIT,
  // Configuration to the radio
  output logic [1:0]       ADDR_WIDTH_FIELD,
  output logic [3:0]       RETRY_COUNT_FIELD,
  output logic             RETRY_GO,
  output logic [6:0]       CHANNEL,
  output logic             CARRIER_ONLY_ENABLE,
  output logic             PLL_LOCK_FORCE,
  output logic [1:0]       DATA_RATE,
  output logic [1:0]       TX_POWER_FIELD,
  output logic             COMM_HOLD,
  output logic             RADIO_IRQ,
  output logic [39:0]      PIPE0_ADDR,
  output logic [39:0]      PIPE1_ADDR,
  output logic [39:0]      PIPE2_ADDR,
  output logic [39:0]      PIPE3_ADDR
);

  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA} rcs_phase_t;

  typedef struct packed {
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_s3;
    logic        csn_s1;
    logic        csn_s2;
    logic        csn_s3;
    logic        mosi_s1;
    logic        mosi_s2;
    rcs_phase_t  phase;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_idx;
    logic [7:0]  cmd;
    logic [7:0]  shin;
    logic [7:0]  shout;
    logic        miso;
    logic [1:0]  aw;
    logic [3:0]  retry_delay_field;
    logic [3:0]  retry_count_field;
    logic [6:0]  ch;
    logic        cw;
    logic        lowr;
    logic        highr;
    logic        pll;
    logic [1:0]  pwr;
    logic        rxdr;
    logic        txds;
    logic        maxrt;
    logic [2:0]  pipe_no;
    logic        txfull;
    logic [3:0]  plos;
    logic [3:0]  arcc;
    logic        power_detect;
    logic [39:0] a0;
    logic [39:0] a1;
    logic [7:0]  a2;
    logic [7:0]  a3;
    logic [39:0] eff0;
    logic [39:0] eff1;
    logic [39:0] eff2;
    logic [39:0] eff3;
    logic        irq;
    logic [1:0]  rate;
    logic [19:0] retry_cnt;
    logic        retry_busy;
    logic        retry_go;
  } rcs_state_t;

  rcs_state_t s_q;
  rcs_state_t s_d;

  function automatic logic [7:0] status_byte(input rcs_state_t s);
    status_byte = {1'b0, s.rxdr, s.txds, s.maxrt, s.pipe_no, s.txfull};
  endfunction

  // Keep only the configured low bytes of an address
  function automatic logic [39:0] trim_addr(input logic [39:0] a, input logic [1:0] aw);
    unique case (aw)
      rcs_pkg::AW_3_BYTES: trim_addr = {16'h0000, a[23:0]};
      rcs_pkg::AW_4_BYTES: trim_addr = {8'h00, a[31:0]};
      default:             trim_addr = a;
    endcase
  endfunction

  // Low-rate bit wins, so the reserved code 11 reads as 250k
  function automatic logic [1:0] rate_code(input logic lowr, input logic highr);
    rate_code = lowr ? rcs_pkg::RATE_250K : (highr ? rcs_pkg::RATE_2M : rcs_pkg::RATE_1M);
  endfunction

  // Read data for one byte of a register; unmapped reads as zero
  function automatic logic [7:0] rd_byte(input rcs_state_t s, input logic [4:0] addr, input logic [2:0] idx);
    rd_byte = 8'h00;
    unique case (addr)
      rcs_pkg::ADDR_AW_SETUP:    rd_byte = {6'h00, s.aw};
      rcs_pkg::ADDR_RETR_SETUP:  rd_byte = {s.retry_delay_field, s.retry_count_field};
      rcs_pkg::ADDR_CHANNEL:     rd_byte = {1'b0, s.ch};
      rcs_pkg::ADDR_RADIO_SETUP: rd_byte = {s.cw, 1'b0, s.lowr, s.pll, s.highr, s.pwr, 1'b0};
      rcs_pkg::ADDR_FLAGS:       rd_byte = status_byte(s);
      rcs_pkg::ADDR_TX_OBSERVE:  rd_byte = {s.plos, s.arcc};
      rcs_pkg::ADDR_POWER_DET:   rd_byte = {7'h00, s.power_detect};
      rcs_pkg::ADDR_PIPE0:       rd_byte = (idx < 3'(rcs_pkg::ADDR_BYTES_MAX)) ? s.a0[{idx, 3'b000} +: 8] : 8'h00;
      rcs_pkg::ADDR_PIPE1:       rd_byte = (idx < 3'(rcs_pkg::ADDR_BYTES_MAX)) ? s.a1[{idx, 3'b000} +: 8] : 8'h00;
      rcs_pkg::ADDR_PIPE2:       rd_byte = s.a2;
      rcs_pkg::ADDR_PIPE3:       rd_byte = s.a3;
      default:                   rd_byte = 8'h00;
    endcase
  endfunction

  logic       sck_rise;
  logic       sck_fall;
  logic       csn_fall;
  logic       wr_pulse;
  logic       ch_wr;
  logic [7:0] wr_byte;
  logic [2:0] wr_idx;
  logic [7:0] byte_v;
  logic [7:0] clr;
  logic       tx_set;
  logic [7:0] stat_v;

  always_comb begin
    s_d = s_q;
    wr_pulse = 1'b0;
    ch_wr = 1'b0;
    wr_byte = 8'h00;
    wr_idx = 3'h0;
    byte_v = {s_q.shin[6:0], s_q.mosi_s2};
    clr = 8'h00;
    stat_v = status_byte(s_q);
    // Synchronisers; only stage two and three feed logic
    s_d.sck_s1 = SCK;
    s_d.sck_s2 = s_q.sck_s1;
    s_d.sck_s3 = s_q.sck_s2;
    s_d.csn_s1 = CSN_B;
    s_d.csn_s2 = s_q.csn_s1;
    s_d.csn_s3 = s_q.csn_s2;
    s_d.mosi_s1 = MOSI;
    s_d.mosi_s2 = s_q.mosi_s1;
    sck_rise = s_q.sck_s2 & ~s_q.sck_s3;
    sck_fall = ~s_q.sck_s2 & s_q.sck_s3;
    csn_fall = ~s_q.csn_s2 & s_q.csn_s3;
    // Serial frame: mode 0, sample on rise, shift on fall
    if (s_q.csn_s2) begin
      s_d.phase = PH_IDLE;
    end else if (csn_fall) begin
      s_d.phase = PH_CMD;
      s_d.bit_cnt = 3'h0;
      s_d.byte_idx = 3'h0;
      s_d.miso = stat_v[7];
      s_d.shout = {stat_v[6:0], 1'b0};
    end else if (sck_rise) begin
      s_d.shin = byte_v;
      s_d.bit_cnt = s_q.bit_cnt + 3'h1;
      if (s_q.bit_cnt == 3'h7) begin
        if (s_q.phase == PH_CMD) begin
          s_d.cmd = byte_v;
          s_d.phase = PH_DATA;
          s_d.shout = (byte_v[7:5] == rcs_pkg::CMD_READ) ? rd_byte(s_q, byte_v[4:0], 3'h0) : 8'h00;
        end else if (s_q.phase == PH_DATA) begin
          // Unknown opcodes are ignored; byte index sticks at 7
          wr_pulse = (s_q.cmd[7:5] == rcs_pkg::CMD_WRITE);
          wr_byte = byte_v;
          wr_idx = s_q.byte_idx;
          if (s_q.byte_idx != 3'h7) begin
            s_d.byte_idx = s_q.byte_idx + 3'h1;
          end
          s_d.shout = (s_q.cmd[7:5] == rcs_pkg::CMD_READ) ? rd_byte(s_q, s_q.cmd[4:0], s_d.byte_idx) : 8'h00;
        end
      end
    end else if (sck_fall) begin
      s_d.miso = s_q.shout[7];
      s_d.shout = {s_q.shout[6:0], 1'b0};
    end
    // Register writes; read-only registers have no case
    if (wr_pulse) begin
      unique case (s_q.cmd[4:0])
        rcs_pkg::ADDR_AW_SETUP: s_d.aw = wr_byte[1:0];
        rcs_pkg::ADDR_RETR_SETUP: begin
          s_d.retry_delay_field = wr_byte[rcs_pkg::RETRY_DELAY_LSB +: 4];
          s_d.retry_count_field = wr_byte[3:0];
        end
        rcs_pkg::ADDR_CHANNEL: begin
          s_d.ch = wr_byte[6:0];
          ch_wr = 1'b1;
        end
        rcs_pkg::ADDR_RADIO_SETUP: begin
          s_d.cw = wr_byte[rcs_pkg::CARRIER_BIT];
          s_d.lowr = wr_byte[rcs_pkg::LOW_RATE_BIT];
          s_d.pll = wr_byte[rcs_pkg::PLL_FORCE_BIT];
          s_d.highr = wr_byte[rcs_pkg::HIGH_RATE_BIT];
          s_d.pwr = wr_byte[rcs_pkg::TX_POWER_LSB +: 2];
        end
        rcs_pkg::ADDR_FLAGS: clr = wr_byte;
        rcs_pkg::ADDR_PIPE0: begin
          if (wr_idx < 3'(rcs_pkg::ADDR_BYTES_MAX)) begin
            s_d.a0[{wr_idx, 3'b000} +: 8] = wr_byte;
          end
        end
        rcs_pkg::ADDR_PIPE1: begin
          if (wr_idx < 3'(rcs_pkg::ADDR_BYTES_MAX)) begin
            s_d.a1[{wr_idx, 3'b000} +: 8] = wr_byte;
          end
        end
        rcs_pkg::ADDR_PIPE2: s_d.a2 = wr_byte;
        rcs_pkg::ADDR_PIPE3: s_d.a3 = wr_byte;
        default: ;
      endcase
    end
    // Flags: a set in the same cycle as a clear wins
    tx_set = AUTO_ACK_ON ? ACK_RECEIVED_PULSE : TX_SENT_PULSE;
    s_d.rxdr = RX_READY_PULSE | (s_q.rxdr & ~clr[rcs_pkg::RX_READY_BIT]);
    s_d.txds = tx_set | (s_q.txds & ~clr[rcs_pkg::TX_SENT_BIT]);
    s_d.maxrt = RETRY_LIMIT_PULSE | (s_q.maxrt & ~clr[rcs_pkg::RETRY_LIMIT_BIT]);
    s_d.pipe_no = RX_PIPE_NUM;
    s_d.txfull = TX_FIFO_FULL;
    s_d.power_detect = RX_POWER_DETECT;
    s_d.irq = (s_d.rxdr & ~MASK_RX_READY) | (s_d.txds & ~MASK_TX_SENT) | (s_d.maxrt & ~MASK_RETRY_LIMIT);
    // Counters; a channel write beats a lost packet in the same cycle
    if (ch_wr) begin
      s_d.plos = 4'h0;
    end else if (LOST_PACKET_PULSE && s_q.plos != rcs_pkg::COUNT_MAX) begin
      s_d.plos = s_q.plos + 4'h1;
    end
    if (NEW_PACKET_PULSE) begin
      s_d.arcc = 4'h0;
    end else if (RETRANSMIT_PULSE && s_q.arcc != rcs_pkg::COUNT_MAX) begin
      s_d.arcc = s_q.arcc + 4'h1;
    end
    // Retransmit wait timer from end of transmission
    s_d.retry_go = 1'b0;
    if (TX_END_PULSE) begin
      s_d.retry_cnt = 20'((32'(s_q.retry_delay_field) + 32'd1) * RETRY_STEP_CYCLES - 32'd1);
      s_d.retry_busy = 1'b1;
    end else if (s_q.retry_busy) begin
      if (s_q.retry_cnt == 20'h00000) begin
        s_d.retry_go = 1'b1;
        s_d.retry_busy = 1'b0;
      end else begin
        s_d.retry_cnt = s_q.retry_cnt - 20'h00001;
      end
    end
    // Registered views for the radio
    s_d.rate = rate_code(s_d.lowr, s_d.highr);
    s_d.eff0 = trim_addr(s_d.a0, s_d.aw);
    s_d.eff1 = trim_addr(s_d.a1, s_d.aw);
    s_d.eff2 = trim_addr({s_d.a1[39:8], s_d.a2}, s_d.aw);
    s_d.eff3 = trim_addr({s_d.a1[39:8], s_d.a3}, s_d.aw);
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.csn_s1 <= 1'b1;
      s_q.csn_s2 <= 1'b1;
      s_q.csn_s3 <= 1'b1;
      s_q.aw <= rcs_pkg::AW_RST;
      s_q.retry_delay_field <= rcs_pkg::RETRY_DELAY_RST;
      s_q.retry_count_field <= rcs_pkg::RETRY_COUNT_RST;
      s_q.ch <= rcs_pkg::CHANNEL_RST;
      s_q.highr <= rcs_pkg::HIGH_RATE_RST;
      s_q.pwr <= rcs_pkg::TX_POWER_RST;
      s_q.pipe_no <= rcs_pkg::PIPE_NUM_RST;
      s_q.a0 <= rcs_pkg::PIPE0_RST;
      s_q.a1 <= rcs_pkg::PIPE1_RST;
      s_q.a2 <= rcs_pkg::PIPE2_RST;
      s_q.a3 <= rcs_pkg::PIPE3_RST;
      s_q.eff0 <= rcs_pkg::PIPE0_RST;
      s_q.eff1 <= rcs_pkg::PIPE1_RST;
      s_q.eff2 <= {rcs_pkg::PIPE1_RST[39:8], rcs_pkg::PIPE2_RST};
      s_q.eff3 <= {rcs_pkg::PIPE1_RST[39:8], rcs_pkg::PIPE3_RST};
      s_q.rate <= rcs_pkg::RATE_2M;
    end else begin
      s_q <= s_d;
    end
  end

  assign MISO                = s_q.miso;
  assign ADDR_WIDTH_FIELD    = s_q.aw;
  assign RETRY_COUNT_FIELD   = s_q.retry_count_field;
  assign RETRY_GO            = s_q.retry_go;
  assign CHANNEL             = s_q.ch;
  assign CARRIER_ONLY_ENABLE = s_q.cw;
  assign PLL_LOCK_FORCE      = s_q.pll;
  assign DATA_RATE           = s_q.rate;
  assign TX_POWER_FIELD      = s_q.pwr;
  assign COMM_HOLD           = s_q.maxrt;
  assign RADIO_IRQ           = s_q.irq;
  assign PIPE0_ADDR          = s_q.eff0;
  assign PIPE1_ADDR          = s_q.eff1;
  assign PIPE2_ADDR          = s_q.eff2;
  assign PIPE3_ADDR          = s_q.eff3;

  // Checks
  sequence s_chan_write;
    wr_pulse && (s_q.cmd[4:0] == rcs_pkg::ADDR_CHANNEL);
  endsequence

  sequence s_frame_start;
    csn_fall;
  endsequence

  property p_plos_clear;
    @(posedge REF_CLK) disable iff (!RST_B) s_chan_write |=> (s_q.plos == 4'h0);
  endproperty
  a_plos_clear: assert property (p_plos_clear) else $error("lost counter not cleared by channel write");

  property p_plos_sat;
    @(posedge REF_CLK) disable iff (!RST_B)
      (s_q.plos == 4'hF) && !wr_pulse |=> (s_q.plos == 4'hF);
  endproperty
  a_plos_sat: assert property (p_plos_sat) else $error("lost counter left saturation");

  property p_status_first;
    @(posedge REF_CLK) disable iff (!RST_B)
      s_frame_start |=> (MISO == 1'b0) && (s_q.shout[7] == $past(s_q.rxdr)) && (s_q.shout[1] == $past(s_q.txfull));
  endproperty
  a_status_first: assert property (p_status_first) else $error("status not shifted at frame start");

  property p_rx_set;
    @(posedge REF_CLK) disable iff (!RST_B) RX_READY_PULSE |=> s_q.rxdr;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive-ready flag not set");

  property p_flag_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
      s_q.maxrt && !(wr_pulse && s_q.cmd[4:0] == rcs_pkg::ADDR_FLAGS && wr_byte[4]) |=> s_q.maxrt && COMM_HOLD;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("retry-limit flag dropped without a clear");

  property p_irq;
    @(posedge REF_CLK) disable iff (!RST_B)
      ##1 RADIO_IRQ == ((s_q.rxdr && !$past(MASK_RX_READY)) || (s_q.txds && !$past(MASK_TX_SENT))
                        || (s_q.maxrt && !$past(MASK_RETRY_LIMIT)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with flags and masks");

  property p_arc_clear;
    @(posedge REF_CLK) disable iff (!RST_B) NEW_PACKET_PULSE |=> (s_q.arcc == 4'h0);
  endproperty
  a_arc_clear: assert property (p_arc_clear) else $error("retransmit counter not cleared");

  property p_sent_ack;
    @(posedge REF_CLK) disable iff (!RST_B)
      AUTO_ACK_ON && TX_SENT_PULSE && !ACK_RECEIVED_PULSE && !s_q.txds |=> !s_q.txds;
  endproperty
  a_sent_ack: assert property (p_sent_ack) else $error("sent flag set before acknowledge");

  property p_pipe_num;
    @(posedge REF_CLK) disable iff (!RST_B) 1'b1 |=> (s_q.pipe_no == $past(RX_PIPE_NUM));
  endproperty
  a_pipe_num: assert property (p_pipe_num) else $error("pipe number not tracked");

  property p_trim3;
    @(posedge REF_CLK) disable iff (!RST_B) (ADDR_WIDTH_FIELD == 2'h1) |-> (PIPE0_ADDR[39:24] == 16'h0000);
  endproperty
  a_trim3: assert property (p_trim3) else $error("address not trimmed to 3 bytes");

endmodule // rcs_regs

/* File: rcs_regs_tb.sv */
// Self-checking bench for the radio register bank
`timescale 1ns/1ps
module rcs_regs_tb;
  logic        ref_clk, rst_b, sck, csn_b, mosi, miso;
  logic [7:0]  ev;
  logic [2:0]  pipe_num, mask;
  logic        auto_ack, fifo_full, pwr_det;
  logic [1:0]  aw, rate, pwr;
  logic [3:0]  rcnt;
  logic        go, carrier, pll, hold, irq;
  logic [6:0]  chan;
  logic [39:0] a0, a1, a2, a3, rd, m;
  logic [7:0]  st;
  int          n_errors, tests_run, n;

  // Reset value of register 03 plus i
  function automatic logic [39:0] rst_v(input int i);
    case (i)
      0, 1:    rst_v = 40'h03;
      2:       rst_v = 40'h02;
      3, 4:    rst_v = 40'h0E;
      7:       rst_v = 40'hE7E7E7E7E7;
      8:       rst_v = 40'hC2C2C2C2C2;
      9:       rst_v = 40'hC3;
      10:      rst_v = 40'hC4;
      default: rst_v = 40'h00;
    endcase
  endfunction

  rcs_regs #(.RETRY_STEP_CYCLES(4)) u_rcs_regs (
    .REF_CLK(ref_clk), .RST_B(rst_b), .SCK(sck), .CSN_B(csn_b), .MOSI(mosi), .MISO(miso),
    .RX_READY_PULSE(ev[0]), .RX_PIPE_NUM(pipe_num), .TX_SENT_PULSE(ev[1]),
    .ACK_RECEIVED_PULSE(ev[2]), .AUTO_ACK_ON(auto_ack), .RETRY_LIMIT_PULSE(ev[3]),
    .TX_FIFO_FULL(fifo_full), .LOST_PACKET_PULSE(ev[4]), .RETRANSMIT_PULSE(ev[5]),
    .NEW_PACKET_PULSE(ev[6]), .TX_END_PULSE(ev[7]), .RX_POWER_DETECT(pwr_det),
    .MASK_RX_READY(mask[2]), .MASK_TX_SENT(mask[1]), .MASK_RETRY_LIMIT(mask[0]),
    .ADDR_WIDTH_FIELD(aw), .RETRY_COUNT_FIELD(rcnt), .RETRY_GO(go), .CHANNEL(chan),
    .CARRIER_ONLY_ENABLE(carrier), .PLL_LOCK_FORCE(pll), .DATA_RATE(rate),
    .TX_POWER_FIELD(pwr), .COMM_HOLD(hold), .RADIO_IRQ(irq),
    .PIPE0_ADDR(a0), .PIPE1_ADDR(a1), .PIPE2_ADDR(a2), .PIPE3_ADDR(a3));

  rcs_spi_master u_rcs_spi_master (.ref_clk(ref_clk), .miso(miso), .sck(sck), .csn_b(csn_b),
    .mosi(mosi));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input int nb, input logic [39:0] d);
    u_rcs_spi_master.frame({rcs_pkg::CMD_WRITE, ad}, nb, d, st, rd);
  endtask

  task automatic rdr(input logic [4:0] ad, input int nb);
    u_rcs_spi_master.frame({rcs_pkg::CMD_READ, ad}, nb, 40'h0, st, rd);
  endtask

  // One-cycle event pulse, returns at the edge that drops it
  task automatic fire(input int i);
    @(posedge ref_clk) ev[i] <= 1'b1;
    @(posedge ref_clk) ev[i] <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    ev = 8'h00;
    pipe_num = 3'h7;
    mask = 3'h0;
    auto_ack = 1'b0;
    fifo_full = 1'b0;
    pwr_det = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      rdr(5'(i + 3), (i == 7 || i == 8) ? 5 : 1);
      chk("reset value", rst_v(i), rd);
      chk("status shift", 40'h0E, {32'h0, st});
    end
    for (int i = 0; i < 4; i++) begin
      wr(rcs_pkg::ADDR_RADIO_SETUP, 1, {32'h0, i[0], 1'b0, i[1], i[1], i[0], i[1:0], 1'b0});
      m = {34'h0, (i[1] ? rcs_pkg::RATE_250K : (i[0] ? rcs_pkg::RATE_2M : rcs_pkg::RATE_1M)), i[0], i[1], i[1:0]};
      chk("radio setup", m, {34'h0, rate, carrier, pll, pwr});
    end
    wr(rcs_pkg::ADDR_PIPE1, 5, 40'h1122334455);
    wr(rcs_pkg::ADDR_PIPE2, 1, 40'h5A);
    rdr(rcs_pkg::ADDR_PIPE1, 5);
    chk("pipe1 read", 40'h1122334455, rd);
    for (int w = 1; w < 4; w++) begin
      wr(rcs_pkg::ADDR_AW_SETUP, 1, 40'(w));
      m = (40'h1 << (8 * (w + 2))) - 40'h1;
      chk("width", 40'(w), {38'h0, aw});
      chk("pipe0", rcs_pkg::PIPE0_RST & m, a0);
      chk("pipe1", 40'h1122334455 & m, a1);
      chk("pipe2", 40'h112233445A & m, a2);
      chk("pipe3", 40'h11223344C4 & m, a3);
    end
    mask <= 3'b010;
    fire(0);
    wr(rcs_pkg::ADDR_FLAGS, 1, 40'h0F);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("rx ready", 40'h14E, {31'h0, irq, st});
    wr(rcs_pkg::ADDR_FLAGS, 1, 40'h40);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("rx cleared", 40'h00E, {31'h0, irq, st});
    fire(1);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("sent masked", 40'h02E, {31'h0, irq, st});
    wr(rcs_pkg::ADDR_FLAGS, 1, 40'h20);
    auto_ack <= 1'b1;
    fire(1);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("sent no ack", 40'h00E, {31'h0, irq, st});
    fire(2);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("sent on ack", 40'h02E, {31'h0, irq, st});
    wr(rcs_pkg::ADDR_FLAGS, 1, 40'h20);
    fire(3);
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("retry limit", 40'h31E, {30'h0, hold, irq, st});
    wr(rcs_pkg::ADDR_FLAGS, 1, 40'h10);
    fifo_full <= 1'b1;
    pipe_num <= 3'h3;
    rdr(rcs_pkg::ADDR_FLAGS, 1);
    chk("limit cleared", 40'h007, {30'h0, hold, irq, st});
    repeat (16) fire(4);
    repeat (3) fire(5);
    wr(rcs_pkg::ADDR_TX_OBSERVE, 1, 40'h00);
    rdr(rcs_pkg::ADDR_TX_OBSERVE, 1);
    chk("observe", 40'hF3, rd);
    fire(6);
    wr(rcs_pkg::ADDR_CHANNEL, 1, 40'h10);
    rdr(rcs_pkg::ADDR_TX_OBSERVE, 1);
    chk("observe cleared", 40'h10_00, {25'h0, chan, rd[7:0]});
    pwr_det <= 1'b1;
    rdr(rcs_pkg::ADDR_POWER_DET, 1);
    chk("power detect", 40'h01, rd);
    rdr(5'h1F, 1);
    chk("undefined", 40'h00, rd);
    wr(rcs_pkg::ADDR_RETR_SETUP, 1, 40'h15);
    chk("retry count", 40'h5, {36'h0, rcnt});
    fire(7);
    #1;
    for (n = 1; n < 200 && go !== 1'b1; n++) @(posedge ref_clk) #1;
    chk("retry wait", 40'(9), 40'(n));
    report_and_stop();
  end
endmodule // rcs_regs_tb

/* File: rcs_spi_master.sv */
// Controller-side serial master model for the register bank
`timescale 1ns/1ps
module rcs_spi_master (
  // Clock
  input  wire logic ref_clk,
  // Serial port
  input  wire logic miso,
  output logic      sck,
  output logic      csn_b,
  output logic      mosi
);
  initial begin
    sck   = 1'b0;
    csn_b = 1'b1;
    mosi  = 1'b0;
  end

  // Byte 0 is the command, then data low byte first; bits MSB first
  task automatic frame(input logic [7:0] cmd, input int nb, input logic [39:0] wd,
                       output logic [7:0] st, output logic [39:0] rd);
    logic [47:0] tx;
    logic [47:0] rx;
    tx = {wd, cmd};
    rx = '0;
    @(posedge ref_clk) csn_b <= 1'b0;
    for (int b = 0; b <= nb; b++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi <= tx[8*b+i];
        // Eight cycles per half period keeps clear of the 3-flop sync
        repeat (8) @(posedge ref_clk);
        sck <= 1'b1;
        rx[8*b+i] = miso;
        repeat (8) @(posedge ref_clk);
        sck <= 1'b0;
      end
    end
    repeat (8) @(posedge ref_clk);
    csn_b <= 1'b1;
    // Released data line must not keep the last bit
    mosi  <= ~mosi;
    repeat (8) @(posedge ref_clk);
    st = rx[7:0];
    rd = rx[47:8];
  endtask
endmodule // rcs_spi_master
